// ===== rtl/dcbrs_seq.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Line read fetches eight words as four doublewords into the fill buffer.
// - Full fill buffer is copied into the cache over three following cycles.
// - A second read may be presented while the first read's data returns.
// - No third request until the first completes; two outstanding at most.
// - A new line read waits while the fill into the cache is running.
// - A single-word read never copies the fill buffer into the cache.
// - Single-word read data is picked from the bus by the byte enables.
// - Next word read waits for the previous one; spacing at least five.
// - Writes are never pipelined; a new write waits for the last to end.
// - Line write drives four beats back to back, first in the ack cycle.
// - Line writes come only from a flush, after two cycles of queuing.
// - At most two flushes pending; a third waits for the first write.
// - Word write data stands in the request cycle; two-cycle minimum spacing.
module dcbrs_seq
  import dcbrs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Cache core requests
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire dcbrs_cmd_e cmd_kind,
  input wire logic [ADDR_W-1:0] cmd_addr,
  input wire logic [WBE_W-1:0] cmd_be,
  input wire logic [WORD_W-1:0] cmd_wdata,
  // Flush of a victim line
  input wire logic flush_valid,
  output logic flush_ready,
  input wire logic [ADDR_W-1:0] flush_addr,
  input wire logic [LINE_W-1:0] flush_line,
  // Word read answer
  output logic rsp_valid,
  output logic [WORD_W-1:0] rsp_data,
  // Fill into the cache array
  output logic fill_valid,
  output logic [ADDR_W-1:0] fill_addr,
  output logic [LINE_W-1:0] fill_line,
  // Data-side bus request
  output logic bus_req,
  output logic [ADDR_W-1:0] bus_addr,
  output logic bus_rnw,
  output logic bus_line,
  output logic [BE_W-1:0] bus_be,
  input wire logic bus_addr_ack,
  // Data-side bus read data
  input wire logic bus_rd_dack,
  input wire logic [DW_W-1:0] bus_rd_data,
  input wire logic [2:0] bus_rd_wdaddr,
  // Data-side bus write data
  input wire logic bus_wr_dack,
  output logic [DW_W-1:0] bus_wr_data
);

  // Presented request
  logic req_ff;
  logic [ADDR_W-1:0] req_addr_ff;
  logic req_rnw_ff;
  logic req_line_ff;
  logic [BE_W-1:0] req_be_ff;
  // Outstanding reads, head at index 0
  logic [1:0] rd_cnt_ff;
  logic rd_line_ff [MAX_OUTSTANDING];
  logic [BE_W-1:0] rd_be_ff [MAX_OUTSTANDING];
  logic [ADDR_W-1:0] rd_addr_ff [MAX_OUTSTANDING];
  logic [1:0] rd_beat_ff;
  logic [1:0] rd_hold_ff;
  // Write in flight
  logic wr_act_ff;
  logic wr_line_ff;
  logic [1:0] wr_beat_ff;
  logic [DW_W-1:0] wr_data_ff;
  // Flush queue
  logic flush_wptr_ff;
  logic flush_rptr_ff;
  logic [FLUSH_SLOTS-1:0] slot_empty;
  logic [FLUSH_SLOTS-1:0] slot_queuing;
  logic [FLUSH_SLOTS-1:0] slot_ready;
  logic [FLUSH_SLOTS-1:0] slot_load;
  logic [FLUSH_SLOTS-1:0] slot_release;
  logic [ADDR_W-1:0] slot_addr [FLUSH_SLOTS];
  logic [LINE_W-1:0] slot_line [FLUSH_SLOTS];
  // Answer registers
  logic rsp_valid_ff;
  logic [WORD_W-1:0] rsp_data_ff;
  // Decisions
  logic cap;
  logic lw_go;
  logic cmd_ok;
  logic cmd_go;
  logic load;
  logic word_rd_busy;
  logic fill_hold;
  logic rd_done;
  logic rd_line_beat;
  logic wr_done;
  logic acked;
  logic push_rd;
  logic flush_take;
  logic [1:0] rd_base;
  logic [LINE_W-1:0] cur_line;
  logic [DW_W-1:0] masked;

  // Completion of the head read and of the running write
  assign rd_line_beat = bus_rd_dack && rd_line_ff[0];
  assign rd_done = bus_rd_dack && (!rd_line_ff[0] || rd_beat_ff == BEAT_LAST);
  assign wr_done = bus_wr_dack && (!wr_line_ff || wr_beat_ff == BEAT_LAST);
  assign acked = req_ff && bus_addr_ack;
  assign push_rd = acked && req_rnw_ff;

  // Two requests at most, a slot is freed only by a completed request
  assign cap = !req_ff
    && ({1'b0, rd_cnt_ff} + {2'b00, wr_act_ff}) < OUTSTANDING_MAX;

  assign word_rd_busy = (rd_cnt_ff != RST_CNT && !rd_line_ff[0])
    || (rd_cnt_ff == 2'h2 && !rd_line_ff[1]);

  // Line writes only from a queued flush and never behind another write
  assign lw_go = cap && !wr_act_ff && slot_ready[flush_rptr_ff];

  always_comb
  begin
    cmd_ok = 1'b0;
    unique case (cmd_kind)
      CMD_LINE_READ: cmd_ok = !fill_hold && !(rd_line_beat && rd_done);
      CMD_WORD_READ: cmd_ok = !word_rd_busy && rd_hold_ff == RST_CNT;
      CMD_WORD_WRITE: cmd_ok = !wr_act_ff;
    endcase
  end

  assign cmd_go = cap && !lw_go && cmd_valid && cmd_ok;
  assign cmd_ready = cmd_go;
  assign load = lw_go || cmd_go;

  // Request is held until acknowledged; ack may come in the same cycle
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      req_ff <= 1'b0;
      req_addr_ff <= RST_ADDR;
      req_rnw_ff <= 1'b0;
      req_line_ff <= 1'b0;
      req_be_ff <= RST_BE;
    end
    else if (load)
    begin
      req_ff <= 1'b1;
      if (lw_go)
      begin
        req_addr_ff <= slot_addr[flush_rptr_ff];
        req_rnw_ff <= 1'b0;
        req_line_ff <= 1'b1;
        req_be_ff <= {BE_W{1'b1}};
      end
      else
      begin
        req_addr_ff <= cmd_addr;
        req_rnw_ff <= (cmd_kind != CMD_WORD_WRITE);
        req_line_ff <= (cmd_kind == CMD_LINE_READ);
        if (cmd_kind == CMD_LINE_READ)
          req_be_ff <= {BE_W{1'b1}};
        else if (cmd_addr[2])
          req_be_ff <= {4'h0, cmd_be};
        else
          req_be_ff <= {cmd_be, 4'h0};
      end
    end
    else if (acked)
      req_ff <= 1'b0;
  end

  // Outstanding read list; the bus unit answers in order
  assign rd_base = rd_done ? rd_cnt_ff - 2'h1 : rd_cnt_ff;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_cnt_ff <= RST_CNT;
      for (int k = 0; k < MAX_OUTSTANDING; k++)
      begin
        rd_line_ff[k] <= 1'b0;
        rd_be_ff[k] <= RST_BE;
        rd_addr_ff[k] <= RST_ADDR;
      end
    end
    else
    begin
      if (rd_done)
      begin
        rd_line_ff[0] <= rd_line_ff[1];
        rd_be_ff[0] <= rd_be_ff[1];
        rd_addr_ff[0] <= rd_addr_ff[1];
      end
      if (push_rd)
      begin
        rd_line_ff[rd_base[0]] <= req_line_ff;
        rd_be_ff[rd_base[0]] <= req_be_ff;
        rd_addr_ff[rd_base[0]] <= req_addr_ff;
      end
      rd_cnt_ff <= rd_base + {1'b0, push_rd};
    end
  end

  // Beat counter of the line read at the head
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      rd_beat_ff <= RST_CNT;
    else if (rd_done)
      rd_beat_ff <= RST_CNT;
    else if (rd_line_beat)
      rd_beat_ff <= rd_beat_ff + 2'h1;
  end

  // Byte enables choose the live bytes of a single-word read
  always_comb
  begin
    for (int k = 0; k < BE_W; k++)
      masked[k*8 +: 8] = rd_be_ff[0][k] ? bus_rd_data[k*8 +: 8] : 8'h00;
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rsp_valid_ff <= 1'b0;
      rsp_data_ff <= RST_WORD;
      rd_hold_ff <= RST_CNT;
    end
    else
    begin
      rsp_valid_ff <= bus_rd_dack && !rd_line_ff[0];
      if (bus_rd_dack && !rd_line_ff[0])
      begin
        rsp_data_ff <= rd_addr_ff[0][2] ? masked[WORD_W-1:0]
                                        : masked[DW_W-1:WORD_W];
        rd_hold_ff <= HOLD_CNT_INIT;
      end
      else if (rd_hold_ff != RST_CNT)
        rd_hold_ff <= rd_hold_ff - 2'h1;
    end
  end

  // Only line reads feed the fill buffer, so word reads never fill
  dcbrs_fill_buf u_fill (
    .core_clk(core_clk),
    .nrst(nrst),
    .beat_valid(rd_line_beat),
    .beat_last(rd_beat_ff == BEAT_LAST),
    .beat_idx(bus_rd_wdaddr[2:1]),
    .beat_data(bus_rd_data),
    .beat_addr(rd_addr_ff[0]),
    .fill_valid(fill_valid),
    .fill_hold(fill_hold),
    .fill_addr(fill_addr),
    .fill_line(fill_line)
  );

  // Write tracking; only a write load restarts it, a read leaves it running
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_act_ff <= 1'b0;
      wr_line_ff <= 1'b0;
      wr_beat_ff <= RST_CNT;
    end
    else
    begin
      if (lw_go || (cmd_go && cmd_kind == CMD_WORD_WRITE))
      begin
        wr_line_ff <= lw_go;
        wr_beat_ff <= RST_CNT;
      end
      else if (bus_wr_dack)
        wr_beat_ff <= wr_beat_ff + 2'h1;
      if (wr_done)
        wr_act_ff <= 1'b0;
      else if (acked && !req_rnw_ff)
        wr_act_ff <= 1'b1;
    end
  end

  // Write data is ready before the ack so the first beat meets it
  assign cur_line = slot_line[flush_rptr_ff];

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      wr_data_ff <= RST_DWORD;
    else if (lw_go)
      wr_data_ff <= cur_line[DW_W-1:0];
    else if (cmd_go && cmd_kind == CMD_WORD_WRITE)
      wr_data_ff <= {cmd_wdata, cmd_wdata};
    else if (bus_wr_dack && wr_line_ff && wr_beat_ff != BEAT_LAST)
      wr_data_ff <= cur_line[(int'(wr_beat_ff) + 1) * DW_W +: DW_W];
  end

  // Flush queue: one flush queues at a time, slots freed by their write
  assign flush_ready = slot_empty[flush_wptr_ff] && slot_queuing == '0;
  assign flush_take = flush_valid && flush_ready;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      flush_wptr_ff <= 1'b0;
      flush_rptr_ff <= 1'b0;
    end
    else
    begin
      if (flush_take)
        flush_wptr_ff <= !flush_wptr_ff;
      if (wr_done && wr_line_ff)
        flush_rptr_ff <= !flush_rptr_ff;
    end
  end

  for (genvar g = 0; g < FLUSH_SLOTS; g++)
  begin : g_slot
    assign slot_load[g] = flush_take && flush_wptr_ff == 1'(g);
    assign slot_release[g] = wr_done && wr_line_ff
                             && flush_rptr_ff == 1'(g);
    dcbrs_flush_slot u_slot (
      .core_clk(core_clk),
      .nrst(nrst),
      .load(slot_load[g]),
      .load_addr(flush_addr),
      .load_line(flush_line),
      .release_slot(slot_release[g]),
      .empty(slot_empty[g]),
      .queuing(slot_queuing[g]),
      .ready(slot_ready[g]),
      .line_addr(slot_addr[g]),
      .line_data(slot_line[g])
    );
  end

  assign bus_req = req_ff;
  assign bus_addr = req_addr_ff;
  assign bus_rnw = req_rnw_ff;
  assign bus_line = req_line_ff;
  assign bus_be = req_be_ff;
  assign bus_wr_data = wr_data_ff;
  assign rsp_valid = rsp_valid_ff;
  assign rsp_data = rsp_data_ff;

endmodule
`default_nettype wire

// ===== rtl/dcbrs_pkg.sv
package dcbrs_pkg;

  // Widths of the data-side bus and of a cache line
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DW_W = 64;
  localparam int unsigned WORD_W = 32;
  localparam int unsigned BE_W = 8;
  localparam int unsigned WBE_W = 4;
  localparam int unsigned LINE_BEATS = 4;
  localparam int unsigned LINE_W = DW_W * LINE_BEATS;
  localparam int unsigned LINE_OFS_W = 5;

  // Sequencing figures, times in core_clk cycles
  localparam int unsigned FILL_CYCLES = 3;
  localparam int unsigned FLUSH_CYCLES = 2;
  localparam int unsigned FLUSH_SLOTS = 2;
  localparam int unsigned MAX_OUTSTANDING = 2;
  localparam int unsigned WORD_READ_SPACING = 5;
  // Request cycle, data cycle and reload cycle are already spent
  localparam int unsigned WORD_READ_HOLD = WORD_READ_SPACING - 3;

  // Counter load values
  localparam logic [1:0] BEAT_LAST = 2'(LINE_BEATS - 1);
  localparam logic [1:0] FILL_CNT_INIT = 2'(FILL_CYCLES);
  localparam logic [1:0] FLUSH_CNT_INIT = 2'(FLUSH_CYCLES - 1);
  localparam logic [1:0] HOLD_CNT_INIT = 2'(WORD_READ_HOLD);
  localparam logic [2:0] OUTSTANDING_MAX = 3'(MAX_OUTSTANDING);

  // Values after reset
  localparam logic [1:0] RST_CNT = 2'h0;
  localparam logic [ADDR_W-1:0] RST_ADDR = 32'h0;
  localparam logic [DW_W-1:0] RST_DWORD = 64'h0;
  localparam logic [WORD_W-1:0] RST_WORD = 32'h0;
  localparam logic [BE_W-1:0] RST_BE = 8'h0;
  localparam logic [LINE_W-1:0] RST_LINE = {LINE_BEATS{RST_DWORD}};

  // Request kinds offered by the cache core
  typedef enum logic [1:0]
  {
    CMD_LINE_READ,
    CMD_WORD_READ,
    CMD_WORD_WRITE
  } dcbrs_cmd_e;

  // Flush queue slot states
  typedef enum logic [1:0]
  {
    SLOT_EMPTY,
    SLOT_QUEUE,
    SLOT_READY
  } dcbrs_slot_e;

endpackage

// ===== rtl/dcbrs_flush_slot.sv
`timescale 1ns/1ps
`default_nettype none
module dcbrs_flush_slot
  import dcbrs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Victim line in, slot freed out
  input wire logic load,
  input wire logic [ADDR_W-1:0] load_addr,
  input wire logic [LINE_W-1:0] load_line,
  input wire logic release_slot,
  // Slot state
  output logic empty,
  output logic queuing,
  output logic ready,
  output logic [ADDR_W-1:0] line_addr,
  output logic [LINE_W-1:0] line_data
);

  dcbrs_slot_e state_ff;
  logic [1:0] cnt_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [LINE_W-1:0] data_ff;

  // Flush occupies a fixed number of cycles before the write may go
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_ff <= SLOT_EMPTY;
      cnt_ff <= RST_CNT;
    end
    else
    begin
      unique case (state_ff)
        SLOT_EMPTY:
        begin
          if (load)
          begin
            state_ff <= SLOT_QUEUE;
            cnt_ff <= FLUSH_CNT_INIT;
          end
        end
        SLOT_QUEUE:
        begin
          if (cnt_ff == RST_CNT)
            state_ff <= SLOT_READY;
          else
            cnt_ff <= cnt_ff - 2'h1;
        end
        SLOT_READY:
        begin
          if (release_slot)
            state_ff <= SLOT_EMPTY;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      addr_ff <= RST_ADDR;
      data_ff <= RST_LINE;
    end
    else if (load && state_ff == SLOT_EMPTY)
    begin
      addr_ff <= load_addr;
      data_ff <= load_line;
    end
  end

  assign empty = (state_ff == SLOT_EMPTY);
  assign queuing = (state_ff == SLOT_QUEUE);
  assign ready = (state_ff == SLOT_READY);
  assign line_addr = addr_ff;
  assign line_data = data_ff;

endmodule
`default_nettype wire

// ===== rtl/dcbrs_fill_buf.sv
`timescale 1ns/1ps
`default_nettype none
module dcbrs_fill_buf
  import dcbrs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Line read beats
  input wire logic beat_valid,
  input wire logic beat_last,
  input wire logic [1:0] beat_idx,
  input wire logic [DW_W-1:0] beat_data,
  input wire logic [ADDR_W-1:0] beat_addr,
  // Fill into the cache array
  output logic fill_valid,
  output logic fill_hold,
  output logic [ADDR_W-1:0] fill_addr,
  output logic [LINE_W-1:0] fill_line
);

  logic [DW_W-1:0] collect_ff [LINE_BEATS];
  logic [LINE_W-1:0] merged;
  logic [LINE_W-1:0] fill_line_ff;
  logic [ADDR_W-1:0] fill_addr_ff;
  logic [1:0] fill_cnt_ff;

  // Beats land by their doubleword index, so return order does not matter
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int k = 0; k < LINE_BEATS; k++)
        collect_ff[k] <= RST_DWORD;
    end
    else if (beat_valid)
      collect_ff[beat_idx] <= beat_data;
  end

  always_comb
  begin
    for (int k = 0; k < LINE_BEATS; k++)
      merged[k*DW_W +: DW_W] = (beat_idx == 2'(k)) ? beat_data
                                                   : collect_ff[k];
  end

  // Snapshot frees the collector for the next line while the fill runs
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fill_line_ff <= RST_LINE;
      fill_addr_ff <= RST_ADDR;
      fill_cnt_ff <= RST_CNT;
    end
    else if (beat_valid && beat_last)
    begin
      fill_line_ff <= merged;
      fill_addr_ff <= {beat_addr[ADDR_W-1:LINE_OFS_W], 5'h00};
      fill_cnt_ff <= FILL_CNT_INIT;
    end
    else if (fill_cnt_ff != RST_CNT)
      fill_cnt_ff <= fill_cnt_ff - 2'h1;
  end

  assign fill_valid = (fill_cnt_ff != RST_CNT);
  // High while more than the final fill cycle remains
  assign fill_hold = (fill_cnt_ff > 2'h1);
  assign fill_addr = fill_addr_ff;
  assign fill_line = fill_line_ff;

endmodule
`default_nettype wire

// ===== verification/dcbrs_seq_properties.sv
`timescale 1ns/1ps
`default_nettype none
module dcbrs_seq_properties
  import dcbrs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic nrst,
  // Core side
  input wire logic cmd_valid,
  input wire logic flush_valid,
  input wire logic flush_ready,
  input wire logic rsp_valid,
  input wire logic fill_valid,
  // Bus side
  input wire logic bus_req,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic bus_rnw,
  input wire logic bus_line,
  input wire logic [BE_W-1:0] bus_be,
  input wire logic bus_addr_ack,
  input wire logic bus_rd_dack,
  input wire logic bus_wr_dack
);
  logic [3:0] rd_n_ff;
  logic [2:0] wr_n_ff;
  logic wl_ff;
  logic [1:0] fl_n_ff;
  logic go_rd;
  logic go_wr;
  logic wl_done;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);

  assign go_rd = bus_req && bus_addr_ack && bus_rnw;
  assign go_wr = bus_req && bus_addr_ack && !bus_rnw;
  assign wl_done = bus_wr_dack && wr_n_ff == 3'h1 && wl_ff;

  // Beats still owed on each data bus
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_n_ff <= 4'h0;
      wr_n_ff <= 3'h0;
      wl_ff <= 1'b0;
    end
    else
    begin
      rd_n_ff <= rd_n_ff + (go_rd ? (bus_line ? 4'h4 : 4'h1) : 4'h0)
        - {3'h0, bus_rd_dack};
      wr_n_ff <= wr_n_ff + (go_wr ? (bus_line ? 3'h4 : 3'h1) : 3'h0)
        - {2'h0, bus_wr_dack};
      if (go_wr)
        wl_ff <= bus_line;
    end
  end

  // Flushes taken but not yet fully written
  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      fl_n_ff <= 2'h0;
    else
      fl_n_ff <= fl_n_ff + {1'b0, flush_valid && flush_ready}
        - {1'b0, wl_done};
  end

  sequence s_fill;
    fill_valid [*3] ##1 !fill_valid;
  endsequence

  sequence s_flush_lead;
    flush_valid && flush_ready && fl_n_ff == 2'h0 && wr_n_ff == 3'h0
      ##1 (!cmd_valid && !bus_req) [*3];
  endsequence

  reset_idle_a:
    assert property ($rose(nrst) |-> !bus_req && !fill_valid && !rsp_valid
      && flush_ready) else $error("busy straight after reset");
  fill_len_a:
    assert property ($rose(fill_valid) |-> s_fill)
    else $error("fill not three cycles");
  req_hold_a:
    assert property (bus_req && !bus_addr_ack |=> bus_req
      && $stable({bus_addr, bus_rnw, bus_line, bus_be}))
    else $error("request changed before ack");
  two_out_a:
    assert property (bus_req |-> !(rd_n_ff != 4'h0 && wr_n_ff != 3'h0))
    else $error("third request presented");
  wr_nopipe_a:
    assert property (bus_req && !bus_rnw |-> wr_n_ff == 3'h0)
    else $error("write pipelined behind write");
  wr_space_a:
    assert property (go_wr && !bus_line |=> !(bus_req && !bus_rnw))
    else $error("word writes too close");
  rd_space_a:
    assert property (go_rd && !bus_line |=>
      !(bus_req && bus_rnw && !bus_line) [*4])
    else $error("word reads too close");
  fill_block_a:
    assert property (fill_valid |-> !$rose(bus_req && bus_rnw && bus_line))
    else $error("line read raised during fill");
  flush_depth_a:
    assert property (fl_n_ff == 2'h2 |-> !flush_ready)
    else $error("third flush accepted");
  flush_lead_a:
    assert property (s_flush_lead |=> bus_req && !bus_rnw && bus_line)
    else $error("line write not raised after flush");
  rsp_cause_a:
    assert property (rsp_valid |-> $past(bus_rd_dack))
    else $error("word answer without read beat");
endmodule
`default_nettype wire

// ===== verification/dcbrs_biu_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcbrs_biu_model
  import dcbrs_pkg::*;
(
  // Clock, reset and pacing
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic stall,
  // Request
  input wire logic bus_req,
  input wire logic [ADDR_W-1:0] bus_addr,
  input wire logic bus_rnw,
  input wire logic bus_line,
  input wire logic [BE_W-1:0] bus_be,
  output logic bus_addr_ack,
  // Read data
  output logic bus_rd_dack,
  output logic [DW_W-1:0] bus_rd_data,
  output logic [2:0] bus_rd_wdaddr,
  // Write data
  output logic bus_wr_dack,
  input wire logic [DW_W-1:0] bus_wr_data,
  output logic [DW_W-1:0] stored_ff
);
  logic [2:0] rd_left_ff;
  logic [1:0] rd_idx_ff;
  logic [1:0] wr_left_ff;
  logic [ADDR_W-1:0] rd_addr_ff;

  // Ack at once when idle, never while an earlier transfer runs
  assign bus_addr_ack = bus_req && !stall && rd_left_ff == 3'h0
    && !bus_rd_dack && wr_left_ff == 2'h0;
  assign bus_wr_dack = (bus_addr_ack && !bus_rnw) || wr_left_ff != 2'h0;

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rd_left_ff <= 3'h0;
      rd_idx_ff <= 2'h0;
      rd_addr_ff <= RST_ADDR;
      bus_rd_dack <= 1'b0;
      bus_rd_data <= RST_DWORD;
      bus_rd_wdaddr <= 3'h0;
    end
    else
    begin
      bus_rd_dack <= rd_left_ff != 3'h0 && !stall;
      bus_rd_data <= ~bus_rd_data;
      bus_rd_wdaddr <= {rd_idx_ff, 1'b0};
      if (bus_addr_ack && bus_rnw)
      begin
        rd_left_ff <= bus_line ? 3'h4 : 3'h1;
        rd_idx_ff <= bus_addr[4:3];
        rd_addr_ff <= bus_addr;
      end
      else if (rd_left_ff != 3'h0 && !stall)
      begin
        bus_rd_data <= {rd_addr_ff[31:5], rd_idx_ff, 3'h3,
          ~rd_addr_ff[31:5], ~rd_idx_ff, 3'h5};
        rd_left_ff <= rd_left_ff - 3'h1;
        rd_idx_ff <= rd_idx_ff + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wr_left_ff <= 2'h0;
      stored_ff <= RST_DWORD;
    end
    else
    begin
      if (bus_addr_ack && !bus_rnw && bus_line)
        wr_left_ff <= 2'h3;
      else if (wr_left_ff != 2'h0)
        wr_left_ff <= wr_left_ff - 2'h1;
      for (int b = 0; b < BE_W; b++)
        if (bus_wr_dack && bus_be[b])
          stored_ff[8*b +: 8] <= bus_wr_data[8*b +: 8];
    end
  end
endmodule
`default_nettype wire

// ===== verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import dcbrs_pkg::*;
;
  logic core_clk, nrst, cmd_valid, cmd_ready, flush_valid, flush_ready;
  logic rsp_valid, fill_valid, bus_req, bus_rnw, bus_line, bus_addr_ack;
  logic bus_rd_dack, bus_wr_dack, stall, slow, prev_fill;
  dcbrs_cmd_e cmd_kind;
  logic [WBE_W-1:0] cmd_be;
  logic [BE_W-1:0] bus_be;
  logic [2:0] bus_rd_wdaddr;
  logic [WORD_W-1:0] cmd_wdata, rsp_data;
  logic [ADDR_W-1:0] cmd_addr, flush_addr, fill_addr, bus_addr;
  logic [LINE_W-1:0] flush_line, fill_line;
  logic [DW_W-1:0] bus_rd_data, bus_wr_data;
  logic [WORD_W-1:0] rq[$];
  logic [LINE_W+ADDR_W-1:0] fq[$];
  logic [ADDR_W+DW_W+BE_W-1:0] wq[$];
  logic [ADDR_W+DW_W+BE_W-1:0] we;
  int bad_count, tests_run, seed, i;

  dcbrs_seq dut (.core_clk, .nrst, .cmd_valid, .cmd_ready, .cmd_kind,
    .cmd_addr, .cmd_be, .cmd_wdata, .flush_valid, .flush_ready, .flush_addr,
    .flush_line, .rsp_valid, .rsp_data, .fill_valid, .fill_addr, .fill_line,
    .bus_req, .bus_addr, .bus_rnw, .bus_line, .bus_be, .bus_addr_ack,
    .bus_rd_dack, .bus_rd_data, .bus_rd_wdaddr, .bus_wr_dack, .bus_wr_data);
  dcbrs_biu_model biu (.core_clk, .nrst, .stall, .bus_req, .bus_addr,
    .bus_rnw, .bus_line, .bus_be, .bus_addr_ack, .bus_rd_dack, .bus_rd_data,
    .bus_rd_wdaddr, .bus_wr_dack, .bus_wr_data, .stored_ff());

  function automatic logic [DW_W-1:0] dw_of(logic [31:0] a, logic [1:0] k);
    return {a[31:5], k, 3'h3, ~a[31:5], ~k, 3'h5};
  endfunction

  function automatic logic [WORD_W-1:0] pick(logic [31:0] a, logic [3:0] be);
    logic [DW_W-1:0] d;
    logic [WORD_W-1:0] w;
    d = dw_of(a, a[4:3]);
    w = a[2] ? d[31:0] : d[63:32];
    for (int b = 0; b < 4; b++)
      if (!be[b])
        w[8*b +: 8] = 8'h00;
    return w;
  endfunction

  task automatic check(input logic [287:0] seen, input logic [287:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic send_cmd(input dcbrs_cmd_e k);
    int n;
    cmd_kind = k;
    cmd_addr = $random(seed);
    cmd_be = 4'($random(seed));
    cmd_wdata = $random(seed);
    if (k == CMD_WORD_READ)
      rq.push_back(pick(cmd_addr, cmd_be));
    else if (k == CMD_LINE_READ)
      fq.push_back({cmd_addr[31:5], 5'h00, dw_of(cmd_addr, 2'h3),
        dw_of(cmd_addr, 2'h2), dw_of(cmd_addr, 2'h1), dw_of(cmd_addr, 2'h0)});
    else
      wq.push_back({cmd_addr, cmd_addr[2] ? {4'h0, cmd_be} : {cmd_be, 4'h0},
        cmd_wdata, cmd_wdata});
    cmd_valid = 1'b1;
    for (n = 0; n < 300; n++)
    begin
      #1;
      if (cmd_ready === 1'b1)
        break;
      @(negedge core_clk);
    end
    @(negedge core_clk);
    check(n < 300, 1'b1);
  endtask

  task automatic send_flush;
    int n;
    flush_addr = $random(seed);
    for (n = 0; n < 8; n++)
      flush_line[32*n +: 32] = $random(seed);
    for (n = 0; n < 4; n++)
      wq.push_back({flush_addr, 8'hFF, flush_line[64*n +: 64]});
    flush_valid = 1'b1;
    for (n = 0; n < 300; n++)
    begin
      #1;
      if (flush_ready === 1'b1)
        break;
      @(negedge core_clk);
    end
    @(negedge core_clk);
    check(n < 300, 1'b1);
  endtask

  initial
  begin
    core_clk = 1'b0;
    forever
      #2.5 core_clk = ~core_clk;
  end

  always @(negedge core_clk)
    stall <= slow && ($random(seed) & 1);

  // Results are matched against the oldest note of their kind
  always @(negedge core_clk)
  begin
    // Look once the falling-edge stall change has settled the acks
    #1;
    if (nrst === 1'b1)
    begin
      if (rsp_valid === 1'b1)
        check(rsp_data, rq.pop_front());
      if (fill_valid === 1'b1 && prev_fill !== 1'b1)
        check({fill_addr, fill_line}, fq.pop_front());
      if (bus_wr_dack === 1'b1)
      begin
        we = wq.pop_front();
        check(bus_wr_data, we[DW_W-1:0]);
        if (bus_req === 1'b1 && bus_rnw === 1'b0)
        begin
          check(bus_be, we[DW_W +: BE_W]);
          check(bus_addr, we[DW_W+BE_W +: ADDR_W]);
        end
      end
    end
    prev_fill = fill_valid;
  end

  initial
  begin
    #300000;
    bad_count++;
    end_sim;
  end

  initial
  begin
    nrst = 1'b0;
    cmd_valid = 1'b0;
    flush_valid = 1'b0;
    slow = 1'b0;
    cmd_kind = CMD_WORD_READ;
    cmd_addr = 32'h0;
    cmd_be = 4'h0;
    cmd_wdata = 32'h0;
    flush_addr = 32'h0;
    flush_line = '0;
    bad_count = 0;
    tests_run = 0;
    seed = 32'h9DFF2EFE;
    repeat (3) @(negedge core_clk);
    nrst = 1'b1;
    #1;
    check({bus_req, fill_valid, rsp_valid, flush_ready}, 4'h1);
    @(negedge core_clk);
    repeat (3) send_cmd(CMD_WORD_WRITE);
    repeat (3) send_cmd(CMD_WORD_READ);
    repeat (3) send_cmd(CMD_LINE_READ);
    cmd_valid = 1'b0;
    repeat (3) send_flush;
    flush_valid = 1'b0;
    slow = 1'b1;
    fork
      begin
        repeat (2) send_flush;
        flush_valid = 1'b0;
      end
      begin
        repeat (8) send_cmd(($random(seed) & 1) ? CMD_LINE_READ
          : CMD_WORD_READ);
        cmd_valid = 1'b0;
      end
    join
    slow = 1'b0;
    for (i = 0; i < 300 && rq.size() + fq.size() + wq.size() != 0; i++)
      @(negedge core_clk);
    check(rq.size() + fq.size() + wq.size(), 0);
    end_sim;
  end
endmodule

bind dcbrs_seq dcbrs_seq_properties props (.core_clk, .nrst, .cmd_valid,
  .flush_valid, .flush_ready, .rsp_valid, .fill_valid, .bus_req, .bus_addr,
  .bus_rnw, .bus_line, .bus_be, .bus_addr_ack, .bus_rd_dack, .bus_wr_dack);
`default_nettype wire
